// ### tpio_chan.sv
// one channel: compare output and capture for general register A
`include "tpio_defs.svh"
`timescale 1ns/1ps
module tpio_chan
   import tpio_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic [3:0] i_mode,
   input wire logic i_ext_src_en,
   input wire logic i_ext_evt,
   input wire logic i_rise,
   input wire logic i_fall,
   input wire logic [15:0] i_count,
   input wire logic i_gr_wr,
   input wire logic [15:0] i_gr_wdata,
   output logic [15:0] o_gr,
   output tpio_chan_out_t o_st
);
   logic [15:0] gr_reg, gr_next;
   logic lvl_reg, lvl_next;
   logic [3:0] mode_q_reg;
   logic is_cap, pin_cap, ext_cap, cap_evt, match;
   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   always_comb begin
      is_cap = i_mode[`TPIO_BIT_MODE];
      // ch5 leaves ext disabled, so bit 2 is ignored there
      ext_cap = is_cap & i_mode[`TPIO_BIT_SRC] & i_ext_src_en & i_ext_evt; // [R10] [R11]
      pin_cap = 1'b0;
      if (is_cap && !(i_mode[`TPIO_BIT_SRC] && i_ext_src_en)) begin // [R6] [R11]
         if (i_mode[`TPIO_BIT_BOTH])
            pin_cap = i_rise | i_fall; // [R9]
         else if (i_mode[0])
            pin_cap = i_fall; // [R8]
         else
            pin_cap = i_rise; // [R7]
      end
      cap_evt = pin_cap | ext_cap;
      match = ~is_cap & (i_count == gr_reg);
   end
   // ----------------------------------------
   // register A and pin level next values
   // ----------------------------------------
   always_comb begin
      gr_next = gr_reg;
      lvl_next = lvl_reg;
      if (cap_evt)
         gr_next = i_count; // [R13]
      else if (i_gr_wr)
         gr_next = i_gr_wdata;
      if (i_mode != mode_q_reg)
         lvl_next = i_mode[`TPIO_BIT_INIT]; // [R1] [R2]
      else if (match) begin
         unique case (i_mode[1:0])
            `TPIO_LOW_CLR: lvl_next = 1'b0; // [R3]
            `TPIO_LOW_SET: lvl_next = 1'b1; // [R4]
            `TPIO_LOW_TGL: lvl_next = ~lvl_reg; // [R5]
            `TPIO_LOW_OFF: lvl_next = lvl_reg;
         endcase
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         gr_reg <= `TPIO_GR_RST;
         lvl_reg <= 1'b0;
         mode_q_reg <= 4'h0;
         o_st <= '0;
      end else if (i_ce) begin
         gr_reg <= gr_next;
         lvl_reg <= lvl_next;
         mode_q_reg <= i_mode;
         o_st.oe <= ~is_cap & (i_mode[1:0] != `TPIO_LOW_OFF); // [R2]
         o_st.lvl <= lvl_next;
         o_st.cap <= cap_evt;
         o_st.match <= match;
      end
   end
   assign o_gr = gr_reg;
endmodule

// ### tpio_defs.svh
// constants for the timer pin i/o mode block
// Functional notes
// R1: codes 0001-0011 set initial pin level low
// R2: codes 0101-0111 initial high; 0000,0100 disable
// R3: low bits 01 drive pin low on match
// R4: low bits 10 drive pin high on match
// R5: low bits 11 toggle pin on match
// R6: ch4 codes 10xx capture from own pin
// R7: pin capture low bits 00: rising edge
// R8: pin capture low bits 01: falling edge
// R9: pin capture bit1 set: both edges
// R10: ch4 codes 11xx capture on ch3 reg A event
// R11: ch5 bit3 set: own pin, bit2 ignored
// R12: ch3 buffer flag set: reg C inert
// R13: capture copies counter into reg A same cycle
`ifndef TPIO_DEFS_SVH
`define TPIO_DEFS_SVH
`define TPIO_ADDR_CTRL4 4'h0
`define TPIO_ADDR_CTRL5 4'h1
`define TPIO_ADDR_GRA4 4'h2
`define TPIO_ADDR_GRA5 4'h3
`define TPIO_ADDR_GRA3 4'h4
`define TPIO_ADDR_GRC3 4'h5
`define TPIO_ADDR_CTRL3 4'h6
`define TPIO_ADDR_STAT 4'h7
`define TPIO_CTRL_RST 8'h00
`define TPIO_GR_RST 16'hFFFF
`define TPIO_BIT_MODE 3
`define TPIO_BIT_SRC 2
`define TPIO_BIT_INIT 2
`define TPIO_BIT_BOTH 1
`define TPIO_BIT_BFA 4
`define TPIO_LOW_OFF 2'b00
`define TPIO_LOW_CLR 2'b01
`define TPIO_LOW_SET 2'b10
`define TPIO_LOW_TGL 2'b11
`define TPIO_NUM_CH 2
`define TPIO_IDX_CH4 0
`define TPIO_IDX_CH5 1
`define TPIO_CNT_STEP 16'h0001
`endif

// ### tpio_pins.sv
// pin-side model: outside drivers on the two timer pins
`timescale 1ns/1ps
module tpio_pins (
   input wire logic i_clk,
   input wire logic [1:0] i_ext,
   input wire logic [1:0] i_slow,
   input wire logic [1:0] i_out,
   input wire logic [1:0] i_oe,
   output logic [1:0] o_wire
);
   logic [1:0] late_reg;
   // a slow driver lands one cycle late
   always_ff @(posedge i_clk) late_reg <= i_ext;
   // the timer wins while it drives its pin
   assign o_wire = (i_oe & i_out) | (~i_oe & ((i_slow & late_reg) | (~i_slow & i_ext)));
endmodule

// ### tpio_pkg.sv
// types for the timer pin i/o mode block
package tpio_pkg;
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } tpio_bus_t;
   typedef struct packed {
      logic oe;
      logic lvl;
      logic cap;
      logic match;
   } tpio_chan_out_t;
endpackage

// ### tpio_sync.sv
// two-flop pin synchroniser with edge detect
`timescale 1ns/1ps
module tpio_sync
   import tpio_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_pin,
   output logic o_rise,
   output logic o_fall
);
   logic s1_reg, s2_reg, s3_reg;
   logic s1_next, s2_next, s3_next;
   // ----------------------------------------
   // stage shift; s1 only feeds s2
   // ----------------------------------------
   always_comb begin
      s1_next = i_pin;
      s2_next = s1_reg;
      s3_next = s2_reg;
   end
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else if (i_ce) begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
      end
   end
   // edges compare stage 2 against stage 3 only
   assign o_rise = s2_reg & ~s3_reg;
   assign o_fall = ~s2_reg & s3_reg;
endmodule

// ### tpio_tb.sv
// self-checking bench for the timer pin i/o top
`timescale 1ns/1ps
module testbench;
   logic i_clk = 0, i_sys_rst = 1, i_ce = 1;
   tpio_pkg::tpio_bus_t bus = '0;
   logic [1:0] ext = '0, slow = '0, pin_w;
   logic [15:0] rdata, cyc = '0, off, t, v;
   logic p4, oe4, p5, oe5, evt;
   int error_cnt = 0, cmp_count = 0;
   // clock, and a cycle count that tracks the timer count
   initial forever #20 i_clk = ~i_clk;
   always @(posedge i_clk) cyc <= cyc + 16'h0001;
   tpio_top dut_u (.i_clk, .i_sys_rst, .i_ce, .i_bus(bus), .i_pin_ch4(pin_w[0]), .i_pin_ch5(pin_w[1]),
      .o_rdata(rdata), .o_pin_ch4(p4), .o_pin_oe_ch4(oe4), .o_pin_ch5(p5), .o_pin_oe_ch5(oe5), .o_ch3_regc_evt(evt));
   tpio_pins pin_u (.i_clk, .i_ext(ext), .i_slow(slow), .i_out({p5, p4}), .i_oe({oe5, oe4}), .o_wire(pin_w));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge i_clk) bus <= '0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge i_clk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge i_clk) bus <= '0;
      #1 d = rdata;
   endtask
   // one outside pin edge; t keeps the cycle it launched in
   task automatic pin(input int ch, input logic lvl);
      @(posedge i_clk) ext[ch] <= lvl;
      t = cyc;
      repeat (6) @(posedge i_clk);
   endtask
   task automatic finish_test;
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // capture source and edge codes; a capture must hold the running count
   task automatic t_cap;
      logic [6:0] tbl [8] = '{7'h68, 7'h59, 7'h7A, 7'h7F, 7'h6C, 7'h28, 7'h19, 7'h3B};
      wr(4'h1, 16'h0008);
      pin(1, 1'b1);
      rd(4'h3, v);
      off = v - t;
      pin(1, 1'b0);
      foreach (tbl[i]) begin
         slow <= {1'b0, ~tbl[i][6]};
         wr({3'b000, tbl[i][6]}, {12'h000, tbl[i][3:0]});
         for (int k = 0; k < 2; k++) begin
            wr({3'b001, tbl[i][6]}, 16'h0000);
            pin(tbl[i][6], k == 0);
            rd({3'b001, tbl[i][6]}, v);
            chk(v, tbl[i][5 - k] ? t + off + {15'h0000, ~tbl[i][6]} : 16'h0000);
         end
      end
   endtask
   // every output code: level after the mode write, then after one match
   task automatic t_cmp;
      for (int i = 0; i < 8; i++) begin
         wr(4'h2, cyc + off + 16'h0040);
         wr(4'h0, i[15:0]);
         @(posedge i_clk);
         #1 chk({oe4, oe4 & p4}, {i[1:0] != 2'b00, i[1:0] != 2'b00 && i[2]});
         repeat (100) @(posedge i_clk);
         #1 chk({oe4, oe4 & p4}, {i[1:0] != 2'b00, i[1] && !(i[0] && i[2])});
      end
   endtask
   // ch4 captures on a ch3 reg A match, registered one cycle
   task automatic t_chain;
      wr(4'h0, 16'h000C);
      wr(4'h2, 16'h0000);
      v = cyc + off + 16'h0020;
      wr(4'h4, v);
      repeat (60) @(posedge i_clk);
      rd(4'h2, t);
      chk(t, v + 16'h0001);
   endtask
   // reg C match pulses once, then stays silent with the buffer flag set
   task automatic t_bfa;
      logic [15:0] n;
      for (int b = 0; b < 2; b++) begin
         n = 16'h0000;
         wr(4'h6, b ? 16'h0010 : 16'h0000);
         wr(4'h5, cyc + off + 16'h0010);
         repeat (50) begin
            @(posedge i_clk);
            #1 n = n + {15'h0000, evt};
         end
         chk(n, b ? 16'h0000 : 16'h0001);
      end
   endtask
   // reset value, an unmapped address, and the byte width of a control register
   task automatic t_regs;
      rd(4'h2, v);
      chk(v, 16'hFFFF);
      wr(4'hF, 16'h1234);
      rd(4'hF, v);
      chk(v, 16'h0000);
      wr(4'h1, 16'hABCD);
      rd(4'h1, v);
      chk(v, 16'h00CD);
   endtask
   // clock enable low: a write offered then must not land; ch4 keeps its 11xx code
   task automatic t_hold;
      @(posedge i_clk) i_ce <= 1'b0;
      wr(4'h0, 16'h0005);
      @(posedge i_clk) i_ce <= 1'b1;
      rd(4'h0, v);
      chk(v, 16'h000C);
   endtask
   initial begin
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      t_regs;
      t_cap;
      t_cmp;
      t_chain;
      t_bfa;
      t_hold;
      finish_test;
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge i_clk);
      error_cnt++;
      finish_test;
   end
endmodule

// ### tpio_top.sv
// top: registers, counter, ch3 event source, channels 4 and 5
`include "tpio_defs.svh"
`timescale 1ns/1ps
module tpio_top
   import tpio_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire tpio_bus_t i_bus,
   input wire logic i_pin_ch4,
   input wire logic i_pin_ch5,
   output logic [15:0] o_rdata,
   output logic o_pin_ch4,
   output logic o_pin_oe_ch4,
   output logic o_pin_ch5,
   output logic o_pin_oe_ch5,
   output logic o_ch3_regc_evt
);
   // ----------------------------------------
   // register bus decode
   // ----------------------------------------
   logic wr_ctrl4;
   logic wr_ctrl5;
   logic wr_ctrl3;
   logic wr_gra4;
   logic wr_gra5;
   logic wr_gra3;
   logic wr_grc3;

   // ----------------------------------------
   // control registers, one byte each
   // ----------------------------------------
   logic [7:0] ctrl4_reg;
   logic [7:0] ctrl4_next;
   logic [7:0] ctrl5_reg;
   logic [7:0] ctrl5_next;
   logic [7:0] ctrl3_reg;
   logic [7:0] ctrl3_next;

   // ----------------------------------------
   // free-running count and the ch3 compare values
   // ----------------------------------------
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic [15:0] gra3_reg;
   logic [15:0] gra3_next;
   logic [15:0] grc3_reg;
   logic [15:0] grc3_next;

   // ----------------------------------------
   // ch3 event pulses and read path
   // ----------------------------------------
   logic ch3_evt_reg;
   logic ch3_evt_next;
   logic regc_evt_next;
   logic [15:0] rdata_next;

   // ----------------------------------------
   // per-channel wiring: index 0 is ch4, index 1 is ch5
   // ----------------------------------------
   logic pin_in [`TPIO_NUM_CH];
   logic pin_rise [`TPIO_NUM_CH];
   logic pin_fall [`TPIO_NUM_CH];
   logic ext_en [`TPIO_NUM_CH];
   logic ext_evt [`TPIO_NUM_CH];
   logic gr_wr [`TPIO_NUM_CH];
   logic [3:0] mode [`TPIO_NUM_CH];
   logic [15:0] gr [`TPIO_NUM_CH];
   tpio_chan_out_t st [`TPIO_NUM_CH];

   // ----------------------------------------
   // write strobe decode
   // ----------------------------------------
   // one hit line per register keeps the next-value groups small
   always_comb begin
      wr_ctrl4 = 1'b0;
      wr_ctrl5 = 1'b0;
      wr_ctrl3 = 1'b0;
      wr_gra4 = 1'b0;
      wr_gra5 = 1'b0;
      wr_gra3 = 1'b0;
      wr_grc3 = 1'b0;
      if (i_bus.wr) begin
         unique case (i_bus.addr)
            `TPIO_ADDR_CTRL4: wr_ctrl4 = 1'b1;
            `TPIO_ADDR_CTRL5: wr_ctrl5 = 1'b1;
            `TPIO_ADDR_CTRL3: wr_ctrl3 = 1'b1;
            `TPIO_ADDR_GRA4: wr_gra4 = 1'b1;
            `TPIO_ADDR_GRA5: wr_gra5 = 1'b1;
            `TPIO_ADDR_GRA3: wr_gra3 = 1'b1;
            `TPIO_ADDR_GRC3: wr_grc3 = 1'b1;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   // software owns these; writes to unmapped addresses fall through
   always_comb begin
      ctrl4_next = ctrl4_reg;
      ctrl5_next = ctrl5_reg;
      ctrl3_next = ctrl3_reg;
      if (wr_ctrl4)
         ctrl4_next = i_bus.wdata[7:0]; // upper byte is dropped, reads back zero
      if (wr_ctrl5)
         ctrl5_next = i_bus.wdata[7:0];
      if (wr_ctrl3)
         ctrl3_next = i_bus.wdata[7:0];
   end

   // register only; frozen while the clock enable is low
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ctrl4_reg <= `TPIO_CTRL_RST;
         ctrl5_reg <= `TPIO_CTRL_RST;
         ctrl3_reg <= `TPIO_CTRL_RST;
      end else if (i_ce) begin
         ctrl4_reg <= ctrl4_next;
         ctrl5_reg <= ctrl5_next;
         ctrl3_reg <= ctrl3_next;
      end
   end

   // ----------------------------------------
   // ch3 register A compare value
   // ----------------------------------------
   // plain storage, software loads it
   always_comb begin
      gra3_next = gra3_reg;
      if (wr_gra3)
         gra3_next = i_bus.wdata;
   end

   // register only
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         gra3_reg <= `TPIO_GR_RST;
      end else if (i_ce) begin
         gra3_reg <= gra3_next;
      end
   end

   // ----------------------------------------
   // ch3 register C compare value
   // ----------------------------------------
   // still writable in buffer mode, it just makes no events then
   always_comb begin
      grc3_next = grc3_reg;
      if (wr_grc3)
         grc3_next = i_bus.wdata;
   end

   // register only
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         grc3_reg <= `TPIO_GR_RST;
      end else if (i_ce) begin
         grc3_reg <= grc3_next;
      end
   end

   // ----------------------------------------
   // timer count
   // ----------------------------------------
   // wraps silently; compares and captures all see this same value
   always_comb begin
      cnt_next = cnt_reg + `TPIO_CNT_STEP;
   end

   // register only
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cnt_reg <= '0;
      end else if (i_ce) begin
         cnt_reg <= cnt_next;
      end
   end

   // ----------------------------------------
   // ch3 register A event
   // ----------------------------------------
   // compare match only; a ch3 capture source is not built here
   always_comb begin
      ch3_evt_next = (cnt_reg == gra3_reg);
   end

   // one cycle of delay, so ch4 takes the count after the match
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ch3_evt_reg <= 1'b0;
      end else if (i_ce) begin
         ch3_evt_reg <= ch3_evt_next;
      end
   end

   // ----------------------------------------
   // ch3 register C event
   // ----------------------------------------
   // buffered reg C makes no compare or capture events
   always_comb begin
      regc_evt_next = ~ctrl3_reg[`TPIO_BIT_BFA] & (cnt_reg == grc3_reg); // [R12]
   end

   // the pulse leaves straight from a flop
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_ch3_regc_evt <= 1'b0;
      end else if (i_ce) begin
         o_ch3_regc_evt <= regc_evt_next;
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   // data stand one cycle only; idle cycles return zero
   always_comb begin
      rdata_next = 16'h0000;
      if (i_bus.rd) begin
         unique case (i_bus.addr)
            `TPIO_ADDR_CTRL4: rdata_next = {8'h00, ctrl4_reg};
            `TPIO_ADDR_CTRL5: rdata_next = {8'h00, ctrl5_reg};
            `TPIO_ADDR_CTRL3: rdata_next = {8'h00, ctrl3_reg};
            `TPIO_ADDR_GRA4: rdata_next = gr[`TPIO_IDX_CH4];
            `TPIO_ADDR_GRA5: rdata_next = gr[`TPIO_IDX_CH5];
            `TPIO_ADDR_GRA3: rdata_next = gra3_reg;
            `TPIO_ADDR_GRC3: rdata_next = grc3_reg;
            `TPIO_ADDR_STAT: rdata_next = {12'h000, st[`TPIO_IDX_CH5].cap, st[`TPIO_IDX_CH5].match,
               st[`TPIO_IDX_CH4].cap, st[`TPIO_IDX_CH4].match};
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   // register only
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_rdata <= 16'h0000;
      end else if (i_ce) begin
         o_rdata <= rdata_next;
      end
   end

   // ----------------------------------------
   // channel wiring
   // ----------------------------------------
   // only ch4 may take the ch3 event, so ch5 ignores mode bit 2 in capture modes
   assign pin_in[`TPIO_IDX_CH4] = i_pin_ch4;
   assign pin_in[`TPIO_IDX_CH5] = i_pin_ch5;
   assign ext_en[`TPIO_IDX_CH4] = 1'b1; // [R10]
   assign ext_en[`TPIO_IDX_CH5] = 1'b0; // [R11]
   assign ext_evt[`TPIO_IDX_CH4] = ch3_evt_reg;
   assign ext_evt[`TPIO_IDX_CH5] = 1'b0;
   assign mode[`TPIO_IDX_CH4] = ctrl4_reg[3:0];
   assign mode[`TPIO_IDX_CH5] = ctrl5_reg[3:0];
   assign gr_wr[`TPIO_IDX_CH4] = wr_gra4;
   assign gr_wr[`TPIO_IDX_CH5] = wr_gra5;

   // ----------------------------------------
   // channels
   // ----------------------------------------
   // same hardware per channel; differences come in through the wiring
   for (genvar ch = 0; ch < `TPIO_NUM_CH; ch++) begin : g_chan
      // pins are asynchronous, two flops before the edge detect
      tpio_sync u_sync (
         .i_clk(i_clk),
         .i_sys_rst(i_sys_rst),
         .i_ce(i_ce),
         .i_pin(pin_in[ch]),
         .o_rise(pin_rise[ch]),
         .o_fall(pin_fall[ch])
      );
      // compare output and capture for register A
      tpio_chan u_chan (
         .i_clk(i_clk),
         .i_sys_rst(i_sys_rst),
         .i_ce(i_ce),
         .i_mode(mode[ch]),
         .i_ext_src_en(ext_en[ch]),
         .i_ext_evt(ext_evt[ch]),
         .i_rise(pin_rise[ch]),
         .i_fall(pin_fall[ch]),
         .i_count(cnt_reg),
         .i_gr_wr(gr_wr[ch]),
         .i_gr_wdata(i_bus.wdata),
         .o_gr(gr[ch]),
         .o_st(st[ch])
      );
   end

   // ----------------------------------------
   // pin outputs
   // ----------------------------------------
   // levels and enables are already flops inside each channel
   assign o_pin_ch4 = st[`TPIO_IDX_CH4].lvl;
   assign o_pin_oe_ch4 = st[`TPIO_IDX_CH4].oe;
   assign o_pin_ch5 = st[`TPIO_IDX_CH5].lvl;
   assign o_pin_oe_ch5 = st[`TPIO_IDX_CH5].oe;
endmodule

// ### tpio_top_sva.sv
// assertion checker on the ports of the timer pin i/o top
`timescale 1ns/1ps
module tpio_top_sva
   import tpio_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire tpio_bus_t i_bus,
   input wire logic i_pin_ch4,
   input wire logic i_pin_ch5,
   input wire logic [15:0] o_rdata,
   input wire logic o_pin_ch4,
   input wire logic o_pin_oe_ch4,
   input wire logic o_pin_ch5,
   input wire logic o_pin_oe_ch5,
   input wire logic o_ch3_regc_evt
);
   logic [3:0] c4_reg, p4_reg, c5_reg, p5_reg;
   logic bf_reg, bp_reg, s4, s5, w;
   // ------------------------------
   // shadow of mode fields, one cycle of history
   // ------------------------------
   assign w = i_ce && i_bus.wr;
   assign s4 = c4_reg == p4_reg;
   assign s5 = c5_reg == p5_reg;
   // history lets a property wait until the pins caught up with a write
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         {c4_reg, p4_reg, c5_reg, p5_reg, bf_reg, bp_reg} <= '0;
      end else begin
         {p4_reg, p5_reg, bp_reg} <= {c4_reg, c5_reg, bf_reg};
         if (w && i_bus.addr == 4'h0) c4_reg <= i_bus.wdata[3:0];
         if (w && i_bus.addr == 4'h1) c5_reg <= i_bus.wdata[3:0];
         if (w && i_bus.addr == 4'h6) bf_reg <= i_bus.wdata[4];
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // a mode change that has settled for one cycle
   sequence s_new4;
      !s4 ##1 s4;
   endsequence
   a_init_low: assert property (s_new4 ##0 c4_reg[3:2] == 2'b00 && c4_reg[1:0] != 2'b00 |-> o_pin_oe_ch4 && !o_pin_ch4)
      else $error("initial level not low");
   a_init_high: assert property (s_new4 ##0 c4_reg[3:2] == 2'b01 && c4_reg[1:0] != 2'b00 |-> o_pin_oe_ch4 && o_pin_ch4)
      else $error("initial level not high");
   a_out_off: assert property (s4 && c4_reg[3:0] inside {4'h0, 4'h4} |-> !o_pin_oe_ch4)
      else $error("pin driven while disabled");
   a_match_low: assert property (s4 && !c4_reg[3] && c4_reg[1:0] == 2'b01 |=> !$rose(o_pin_ch4))
      else $error("pin rose in drive-low mode");
   a_match_high: assert property (s4 && !c4_reg[3] && c4_reg[1:0] == 2'b10 |=> !$fell(o_pin_ch4))
      else $error("pin fell in drive-high mode");
   a_cap4_quiet: assert property (s4 && c4_reg[3] |-> !o_pin_oe_ch4)
      else $error("ch4 pin driven in capture mode");
   a_cap5_quiet: assert property (s5 && c5_reg[3] |-> !o_pin_oe_ch5)
      else $error("ch5 pin driven in capture mode");
   a_buf_quiet: assert property (bf_reg && bp_reg |-> !o_ch3_regc_evt)
      else $error("reg C event while buffered");
endmodule
bind tpio_top tpio_top_sva chk_u (.*);
